// file: core/vicm_consts.svh
// Purpose: Offsets, field positions and reset values of the mapper.
// Assumes: Included by the package and by every design file.
// Notes:   Definitions only.
`ifndef VICM_CONSTS_SVH
`define VICM_CONSTS_SVH

`define VICM_ADDR_W 8
`define VICM_CFG_OFS 8'h4c
`define VICM_CFG_RST 32'h0000_0000
`define VICM_SYNC_IDLE 8'hff
`define VICM_MASK_HI 31
`define VICM_MASK_LO 25
`define VICM_EN_HI 24
`define VICM_EN_LO 17
`define VICM_MAP7_LO 14
`define VICM_MAP6_LO 11
`define VICM_MAP5_LO 8
`define VICM_MAP4_LO 5
`define VICM_MAP3_LO 2
`define VICM_SEL2_BIT 1
`define VICM_SEL1_BIT 0
`define VICM_N_ERR 8
`define VICM_N_LINE 4

`endif

// file: core/vicm_pkg.sv
// Purpose: Types shared by the mapper modules.
// Assumes: Constants come from the header.
// Notes:   Error index k matches enable bit 17+k.
`include "vicm_consts.svh"

package vicm_pkg;

	typedef struct packed {
		logic [31:0] cfg;
		logic [7:0] sync1;
		logic [7:0] sync2;
		logic [7:1] pend;
		logic [`VICM_N_ERR-1:0] err;
		logic [`VICM_N_LINE-1:0] req;
		logic err_irq;
		logic [31:0] rdata;
	} vicm_state_t;

endpackage : vicm_pkg

// file: core/vicm_level_map.sv
// Purpose: Decode one level's map field into a request line and type.
// Assumes: Purely combinational; used once per VME level.
// Notes:   Line index 0 is request line 4, index 3 is line 7.
`timescale 1ns/1ps
`include "vicm_consts.svh"

module vicm_level_map
	import vicm_pkg::*;
(
	input wire logic [2:0] i_field,
	output logic [`VICM_N_LINE-1:0] o_line,
	output logic o_rora
);

	// -----------------------------------------------------------------
	// Field decode
	// -----------------------------------------------------------------
	// A one-hot result guarantees a level never reaches two lines.
	always_comb begin
		o_line = 4'h0;
		o_line[i_field[2:1]] = 1'b1;
		o_rora = i_field[0];
	end

endmodule : vicm_level_map

// file: core/vicm_top.sv
// Purpose: VME interrupt level mask, line mapping and error interrupts.
// Assumes: Error event inputs are one-cycle pulses on I_SYS_CLK.
// Notes:   VME pins pass two flip-flops before any logic reads them.
`timescale 1ns/1ps
`include "vicm_consts.svh"

module vicm_top
	import vicm_pkg::*;
(
	input wire logic I_SYS_CLK,
	input wire logic I_RST,
	input wire logic I_REG_WR,
	input wire logic I_REG_RD,
	input wire logic [`VICM_ADDR_W-1:0] I_REG_ADDR,
	input wire logic [31:0] I_REG_WDATA,
	output logic [31:0] O_REG_RDATA,
	input wire logic [7:1] I_VME_IRQ_N,
	input wire logic I_VME_BERR_N,
	input wire logic I_IACK_STB,
	input wire logic [2:0] I_IACK_LEVEL,
	input wire logic [7:1] I_PEND_CLR,
	input wire logic I_SWAP_PAR_ERR,
	input wire logic [3:0] I_PAR_ERR,
	input wire logic I_ARB_TIMEOUT,
	input wire logic I_BUS_TIMEOUT,
	input wire logic I_INTERLOCK_ERR,
	input wire logic I_PLAIN_READ_LOCKED_PAGE_ERR,
	input wire logic I_UNMAPPED_LOCKED_CYCLE_ERR,
	input wire logic [`VICM_N_ERR-1:0] I_ERR_CLR,
	output logic [`VICM_N_LINE-1:0] O_HOST_REQ,
	output logic O_ERR_IRQ,
	output logic [7:1] O_PENDING,
	output logic [`VICM_N_ERR-1:0] O_ERR_STATUS
);

	// -----------------------------------------------------------------
	// Map field selection
	// -----------------------------------------------------------------
	function automatic logic [2:0] map_field(
		input logic [31:0] cfg,
		input int lvl
	);
		case (lvl)
			7: map_field = cfg[`VICM_MAP7_LO +: 3];
			6: map_field = cfg[`VICM_MAP6_LO +: 3];
			5: map_field = cfg[`VICM_MAP5_LO +: 3];
			4: map_field = cfg[`VICM_MAP4_LO +: 3];
			3: map_field = cfg[`VICM_MAP3_LO +: 3];
			// Levels 2 and 1 only choose the release type.
			2: map_field = {2'b00, cfg[`VICM_SEL2_BIT]};
			default: map_field = {2'b00, cfg[`VICM_SEL1_BIT]};
		endcase
	endfunction : map_field

	vicm_state_t s_q;
	vicm_state_t s_d;
	logic [`VICM_N_LINE-1:0] line_sel [7:1];
	logic [7:1] rora_sel;
	logic [7:1] mask;
	logic [`VICM_N_ERR-1:0] err_en;
	logic [7:1] set_vec;
	logic [7:1] clr_vec;
	logic [`VICM_N_ERR-1:0] err_ev;
	logic cfg_hit;

	assign mask = s_q.cfg[`VICM_MASK_HI:`VICM_MASK_LO];
	assign err_en = s_q.cfg[`VICM_EN_HI:`VICM_EN_LO];
	assign cfg_hit = (I_REG_ADDR == `VICM_CFG_OFS);

	genvar gl;
	generate
		for (gl = 1; gl <= 7; gl++) begin : g_lvl
			vicm_level_map u_map (
				.i_field(map_field(s_q.cfg, gl)),
				.o_line(line_sel[gl]),
				.o_rora(rora_sel[gl])
			);
		end
	endgenerate

	// -----------------------------------------------------------------
	// Next state
	// -----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.sync1 = {I_VME_IRQ_N, I_VME_BERR_N};
		s_d.sync2 = s_q.sync1;

		if (I_REG_WR && cfg_hit) begin
			s_d.cfg = I_REG_WDATA;
		end
		if (I_REG_RD) begin
			s_d.rdata = cfg_hit ? s_q.cfg : 32'h0000_0000;
		end

		// A level is caught only while its mask bit is set, but a later
		// mask write never drops a level that is already pending.
		for (int l = 1; l <= 7; l++) begin
			set_vec[l] = ~s_q.sync2[l] & mask[l];
			if (rora_sel[l]) begin
				clr_vec[l] = I_PEND_CLR[l];
			end else begin
				clr_vec[l] = I_IACK_STB &&
					(I_IACK_LEVEL == 3'(l));
			end
		end
		// For an unmasked level, the line still being held low wins over the release.
		s_d.pend = (s_q.pend & ~clr_vec) | set_vec;

		s_d.req = 4'h0;
		for (int l = 1; l <= 7; l++) begin
			if (s_q.pend[l] && mask[l]) begin
				s_d.req = s_d.req | line_sel[l];
			end
		end

		err_ev[0] = I_UNMAPPED_LOCKED_CYCLE_ERR;
		err_ev[1] = I_PLAIN_READ_LOCKED_PAGE_ERR;
		err_ev[2] = I_INTERLOCK_ERR;
		err_ev[3] = I_BUS_TIMEOUT;
		err_ev[4] = I_ARB_TIMEOUT;
		err_ev[5] = |I_PAR_ERR;
		err_ev[6] = I_SWAP_PAR_ERR;
		err_ev[7] = ~s_q.sync2[0];
		// A new event in the clearing cycle is kept.
		s_d.err = (s_q.err & ~I_ERR_CLR) | err_ev;
		s_d.err_irq = |(s_q.err & err_en);
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_RST) begin
			// Pins idle high, so the synchronisers reset to idle.
			s_q <= '{cfg: `VICM_CFG_RST, sync1: `VICM_SYNC_IDLE,
				sync2: `VICM_SYNC_IDLE, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign O_REG_RDATA = s_q.rdata;
	assign O_HOST_REQ = s_q.req;
	assign O_ERR_IRQ = s_q.err_irq;
	assign O_PENDING = s_q.pend;
	assign O_ERR_STATUS = s_q.err;

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	a_mask_gate_req:
	assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		(mask == 7'h00) |=> (O_HOST_REQ == 4'h0))
	else $error("request line raised with all levels masked");

	a_pend_only_clear:
	assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		(s_q.pend[5] && !clr_vec[5] && I_REG_WR) |=> s_q.pend[5])
	else $error("pending level lost on a register write");

	a_roak_ack_clear:
	assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		(s_q.pend[3] && !rora_sel[3] && s_q.sync2[3] &&
		I_IACK_STB && I_IACK_LEVEL == 3'h3) |=> !s_q.pend[3])
	else $error("acknowledge did not release level 3");

	a_rora_ack_keep:
	assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		(s_q.pend[4] && rora_sel[4] && !I_PEND_CLR[4])
		|=> s_q.pend[4])
	else $error("register-release level 4 dropped without clear");

	a_default_line:
	assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		(s_q.pend[7] && mask[7] &&
		s_q.cfg[`VICM_MAP7_LO +: 3] == 3'h0) |=> O_HOST_REQ[0])
	else $error("zero map field not sent on line 4");

	a_top_line:
	assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		(s_q.pend[6] && mask[6] &&
		s_q.cfg[`VICM_MAP6_LO + 1 +: 2] == 2'h3) |=> O_HOST_REQ[3])
	else $error("map code 11 not sent on line 7");

	a_low_fixed_line:
	assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		(s_q.pend[2] && mask[2]) |=> O_HOST_REQ[0])
	else $error("level 2 not sent on line 4");

	a_err_gate:
	assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		(err_en == 8'h00) |=> !O_ERR_IRQ)
	else $error("error interrupt with all enables clear");

	a_berr_irq:
	assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		(!s_q.sync2[0] && err_en[7] && !I_REG_WR) |=> ##1 O_ERR_IRQ)
	else $error("bus error did not interrupt");

	a_swap_irq:
	assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		(I_SWAP_PAR_ERR && err_en[6] && !I_REG_WR) |=> ##1 O_ERR_IRQ)
	else $error("swap parity error did not interrupt");

	a_par_irq:
	assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		(|I_PAR_ERR && err_en[5] && !I_REG_WR) |=> ##1 O_ERR_IRQ)
	else $error("transfer parity error did not interrupt");

	a_arb_irq:
	assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		(I_ARB_TIMEOUT && err_en[4] && !I_REG_WR) |=> ##1 O_ERR_IRQ)
	else $error("arbitration timeout did not interrupt");

	a_bto_irq:
	assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		(I_BUS_TIMEOUT && err_en[3] && !I_REG_WR) |=> ##1 O_ERR_IRQ)
	else $error("transaction timeout did not interrupt");

	a_lock_irq:
	assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		(I_INTERLOCK_ERR && err_en[2] && !I_REG_WR) |=> ##1 O_ERR_IRQ)
	else $error("interlock error did not interrupt");

	a_plain_irq:
	assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		(I_PLAIN_READ_LOCKED_PAGE_ERR && err_en[1] && !I_REG_WR)
		|=> ##1 O_ERR_IRQ)
	else $error("plain read of locked page did not interrupt");

	a_unmap_irq:
	assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		(I_UNMAPPED_LOCKED_CYCLE_ERR && err_en[0] && !I_REG_WR)
		|=> ##1 O_ERR_IRQ)
	else $error("locked cycle to unmapped page did not interrupt");

	a_cfg_readback:
	assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		(I_REG_WR && cfg_hit) |=> (s_q.cfg == $past(I_REG_WDATA)))
	else $error("configuration write not stored");

	a_masked_no_set:
	assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		(!mask[4] && !s_q.pend[4]) |=> !O_PENDING[4])
	else $error("masked level 4 became pending");

	a_level_set:
	assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		(!s_q.sync2[6] && mask[6]) |=> O_PENDING[6])
	else $error("unmasked level 6 not caught");

	a_ack_other_keep:
	assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		(s_q.pend[7] && !I_PEND_CLR[7] &&
		!(I_IACK_STB && I_IACK_LEVEL == 3'h7)) |=> O_PENDING[7])
	else $error("level 7 released without its acknowledge");

	a_req_needs_pend:
	assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		((s_q.pend & mask) == 7'h00) |=> (O_HOST_REQ == 4'h0))
	else $error("request line raised with nothing pending");

	a_mid_line:
	assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		(s_q.pend[5] && mask[5] &&
		s_q.cfg[`VICM_MAP5_LO + 1 +: 2] == 2'h1) |=> O_HOST_REQ[1])
	else $error("map code 01 not sent on line 5");

	a_upper_line:
	assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		(s_q.pend[4] && mask[4] &&
		s_q.cfg[`VICM_MAP4_LO + 1 +: 2] == 2'h2) |=> O_HOST_REQ[2])
	else $error("map code 10 not sent on line 6");

	a_low1_line:
	assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		(s_q.pend[1] && mask[1]) |=> O_HOST_REQ[0])
	else $error("level 1 not sent on line 4");

	a_read_cfg:
	assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		(I_REG_RD && cfg_hit) |=> (O_REG_RDATA == $past(s_q.cfg)))
	else $error("configuration read returned wrong data");

	a_read_other:
	assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		(I_REG_RD && !cfg_hit) |=> (O_REG_RDATA == 32'h0000_0000))
	else $error("unmapped read not zero");

	a_read_hold:
	assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		!I_REG_RD |=> $stable(O_REG_RDATA))
	else $error("read data changed without a read");

	a_err_hold:
	assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		(s_q.err[3] && !I_ERR_CLR[3]) |=> O_ERR_STATUS[3])
	else $error("bus timeout status lost without a clear");

	a_err_clear:
	assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		(I_ERR_CLR[4] && !I_ARB_TIMEOUT) |=> !O_ERR_STATUS[4])
	else $error("arbitration status not cleared");

	a_arb_status:
	assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		I_ARB_TIMEOUT |=> O_ERR_STATUS[4])
	else $error("arbitration timeout not recorded");

	a_irq_needs_flag:
	assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
		((s_q.err & err_en) == 8'h00) |=> !O_ERR_IRQ)
	else $error("error interrupt without an enabled flag");

endmodule : vicm_top

// file: bench/vicm_vme_model.sv
// Purpose: VME interrupter request lines seen by the mapper.
// Assumes: The bench raises and drops each level by one-cycle pulses.
// Notes:   Lines idle high, as the backplane pull-ups leave them.
`timescale 1ns/1ps

module vicm_vme_model (
	input wire logic i_clk,
	input wire logic [7:1] i_raise,
	input wire logic [7:1] i_drop,
	output logic [7:1] o_irq_n
);
	// The line is let go ahead of the acknowledge, so the mapper already
	// sees it high when the acknowledge pulse arrives.
	initial o_irq_n = 7'h7f;
	always @(posedge i_clk) begin
		o_irq_n <= (o_irq_n & ~i_raise) | i_drop;
	end
endmodule : vicm_vme_model

// file: bench/vme_irq_config_mapper_test.sv
// Purpose: Self-checking bench for the interrupt mapper.
// Assumes: Inputs change by non-blocking assignment at rising edges.
// Notes:   Expected values come from the field layout alone.
`timescale 1ns/1ps

module vme_irq_config_mapper_test;
	import vicm_pkg::*;
	logic clk = 0, rst = 1, wr = 0, rd = 0, iack = 0, eirq;
	logic [7:0] addr = 0, ev = 0, eclr = 0, est;
	logic [31:0] wd = 0, rdata;
	logic [7:1] raise = 0, drop = 0, pclr = 0, irq_n, pend;
	logic [2:0] ilvl = 0;
	logic [3:0] par = 4'h1, req;
	int err_count = 0, checks = 0, cyc = 0;

	always #5 clk = ~clk;
	vicm_vme_model i_vicm_vme_model (.i_clk(clk), .i_raise(raise),
		.i_drop(drop), .o_irq_n(irq_n));
	vicm_top i_vicm_top (.I_SYS_CLK(clk), .I_RST(rst), .I_REG_WR(wr),
		.I_REG_RD(rd), .I_REG_ADDR(addr), .I_REG_WDATA(wd),
		.O_REG_RDATA(rdata), .I_VME_IRQ_N(irq_n), .I_VME_BERR_N(~ev[7]),
		.I_IACK_STB(iack), .I_IACK_LEVEL(ilvl), .I_PEND_CLR(pclr),
		.I_SWAP_PAR_ERR(ev[6]), .I_PAR_ERR(ev[5] ? par : 4'h0),
		.I_ARB_TIMEOUT(ev[4]), .I_BUS_TIMEOUT(ev[3]),
		.I_INTERLOCK_ERR(ev[2]), .I_PLAIN_READ_LOCKED_PAGE_ERR(ev[1]),
		.I_UNMAPPED_LOCKED_CYCLE_ERR(ev[0]), .I_ERR_CLR(eclr),
		.O_HOST_REQ(req), .O_ERR_IRQ(eirq), .O_PENDING(pend),
		.O_ERR_STATUS(est));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic test_done();
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : test_done
	task automatic chk(logic [31:0] seen, logic [31:0] exp, string m);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: %s %h %h", $time, m, seen, exp);
		end
	endtask : chk
	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic wreg(logic [7:0] a, logic [31:0] d);
		@(posedge clk) begin wr <= 1; addr <= a; wd <= d; end
		@(posedge clk) wr <= 0;
	endtask : wreg
	task automatic rreg(logic [7:0] a, logic [31:0] e);
		@(posedge clk) begin rd <= 1; addr <= a; end
		@(posedge clk) rd <= 0;
		tick(1);
		chk(rdata, e, "read");
	endtask : rreg
	task automatic vme(logic [7:1] up, logic [7:1] dn);
		@(posedge clk) begin raise <= up; drop <= dn; end
		@(posedge clk) begin raise <= 0; drop <= 0; end
		tick(5);
	endtask : vme
	task automatic ack(int l);
		@(posedge clk) begin iack <= 1; ilvl <= 3'(l); end
		@(posedge clk) iack <= 0;
		tick(3);
	endtask : ack

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rreg(8'h4c, 32'h0);
		wreg(8'h48, 32'hffff_ffff);
		rreg(8'h48, 32'h0);
		rreg(8'h4c, 32'h0);
		chk({req, eirq, pend, est}, 0, "idle");
	endtask : t_reset
	task automatic t_map(int l, logic [2:0] f);
		logic [31:0] c;
		logic [3:0] line;
		c = 32'hfe00_0000;
		c |= l > 2 ? 32'(f) << (3 * l - 7) : 32'(f[0]) << (l - 1);
		line = l > 2 ? 4'h1 << f[2:1] : 4'h1;
		wreg(8'h4c, c);
		rreg(8'h4c, c);
		vme(7'h1 << (l - 1), 0);
		chk(pend, 7'h1 << (l - 1), "pending");
		chk(req, line, "line");
		vme(0, 7'h1 << (l - 1));
		ack(l);
		chk(pend, f[0] ? 7'h1 << (l - 1) : 0, "ack");
		@(posedge clk) pclr <= 7'h7f;
		@(posedge clk) pclr <= 0;
		tick(3);
		chk({pend, req}, 0, "clear");
	endtask : t_map
	task automatic t_mask();
		wreg(8'h4c, 32'h0);
		vme(7'h04, 0);
		chk(pend, 0, "masked");
		vme(0, 7'h04);
		wreg(8'h4c, 32'hf001_a200);
		vme(7'h74, 0);
		chk({pend, req}, {7'h70, 4'he}, "spread");
		wreg(8'h4c, 32'hb001_a200);
		tick(3);
		chk({pend, req}, {7'h70, 4'ha}, "one off");
		vme(0, 7'h7f);
		@(posedge clk) rst <= 1;
		repeat (3) @(posedge clk);
		rst <= 0;
		t_reset();
	endtask : t_mask
	task automatic t_err(int k);
		for (int e = 0; e < 2; e++) begin
			wreg(8'h4c, 32'(e) << (17 + k));
			@(posedge clk) ev <= 8'h1 << k;
			@(posedge clk) ev <= 0;
			tick(5);
			chk(est, 8'h1 << k, "status");
			chk(eirq, e, "irq");
			@(posedge clk) eclr <= 8'h1 << k;
			@(posedge clk) eclr <= 0;
			tick(3);
			chk({est, eirq}, 0, "cleared");
		end
	endtask : t_err

	// A run far past the expected length means a hung scenario.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 10000) begin
			err_count++;
			test_done();
		end
	end

	initial begin
		repeat (3) @(posedge clk);
		rst <= 0;
		t_reset();
		for (int l = 1; l <= 7; l++) begin
			for (int f = 0; f < (l > 2 ? 8 : 2); f++) begin
				t_map(l, 3'(f));
			end
		end
		t_mask();
		for (int k = 0; k < 8; k++) begin
			t_err(k);
		end
		for (int p = 0; p < 4; p++) begin
			@(posedge clk) par <= 4'h1 << p;
			t_err(5);
		end
		test_done();
	end
endmodule : vme_irq_config_mapper_test
